//--- logic/complementary_output_timing.sv
// Complementary PWM output timing core with AXI4-Lite registers
//
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps

module complementary_output_timing
    import cog_timing_pkg::*;
#(
    parameter int CNT_W = cog_timing_pkg::CNT_W
)
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Event sources and shutdown
    input wire logic rise_src_i,
    input wire logic fall_src_i,
    input wire logic shutdown_active_i,
    // Output drive
    output logic out_a_o,
    output logic out_b_o,
    output logic out_c_o,
    output logic out_d_o,
    output logic out_a_oe_o,
    output logic out_b_oe_o,
    output logic out_c_oe_o,
    output logic out_d_oe_o,
    // AXI4-Lite slave
    input wire logic [cog_timing_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [cog_timing_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import cog_timing_pkg::*;

    localparam int GDW = $clog2(GEN_INT_DIV);
    localparam int CDW = $clog2(DLY_ELEM_CYC + 1);

    // ==========================================================
    // State
    typedef struct packed {
        logic [2:0] rise_sync;
        logic [2:0] fall_sync;
        logic rise_lvl;
        logic fall_lvl;
        logic [CTL_W-1:0] timing_control_reg;
        logic [3:0] pol;
        logic [3:0] steer;
        logic [3:0] sdata;
        logic [3:0] ovr;
        logic [NUM_CNT-1:0][CNT_W-1:0] cnt;
        logic [GDW-1:0] gdiv;
        logic [CDW-1:0] cdiv;
        logic [1:0] mode_prev;
        // One bit wider: the load adds the partial first period
        logic [CNT_W:0] ph_r;
        logic [CNT_W:0] ph_f;
        logic [CNT_W-1:0] bl_r;
        logic [CNT_W-1:0] bl_f;
        logic [CNT_W-1:0] db_r;
        logic [CNT_W-1:0] db_f;
        logic [CNT_W-1:0] dir;
        logic dir_sync;
        logic prim;
        logic comp;
        logic pwm;
        logic [3:0] out;
        logic [3:0] oe;
        logic aw_got;
        logic [AXI_AW-1:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } state_t;

    state_t q;
    state_t n;

    // ==========================================================
    // Decoded control
    logic en;
    logic half;
    logic [1:0] mode;
    logic [1:0] clksel;
    logic [GDW-1:0] gen_lim;
    logic tick;
    logic cstep;
    logic rise_agree;
    logic fall_agree;
    logic rise_in;
    logic fall_in;
    logic rise_ok;
    logic fall_ok;
    logic rev;
    logic fev;
    logic modv;
    logic [3:0] raw;
    logic [3:0] sel_v;
    logic [3:0] sel_e;
    logic [32:0] rd;
    logic [32:0] wr_chk;

    assign en = q.timing_control_reg[CTL_ENABLE];
    assign mode = q.timing_control_reg[CTL_MODE_LSB +: 2];
    assign clksel = q.timing_control_reg[CTL_CLKSEL_LSB +: 2];
    assign half = (mode != MODE_FWD) && (mode != MODE_REV);

    // Generator clock as a strobe on the system clock
    assign gen_lim = (clksel == CS_INT_OSC) ? GDW'(GEN_INT_DIV - 1) :
                     (clksel == CS_INSTR) ? GDW'(GEN_INSTR_DIV - 1) :
                     '0;
    assign tick = (q.gdiv >= gen_lim);
    // Delay chain element time, one system cycle per element
    assign cstep = (q.cdiv >= CDW'(DLY_ELEM_CYC - 1));

    // Edges count once the second and third stages agree
    assign rise_agree = (q.rise_sync[2] == q.rise_sync[1]);
    assign fall_agree = (q.fall_sync[2] == q.fall_sync[1]);
    assign rise_in = rise_agree && q.rise_sync[1] && !q.rise_lvl;
    assign fall_in = fall_agree && q.fall_sync[1] && !q.fall_lvl;
    // Cross-coupled blanking
    assign rise_ok = en && rise_in && (q.bl_f == '0);
    assign fall_ok = en && fall_in && (q.bl_r == '0);
    // Phase stage: zero count passes straight through
    assign rev = (rise_ok && q.cnt[IDX_RISE_PHASE] == '0) ||
                 (en && tick && q.ph_r == (CNT_W + 1)'(1));
    assign fev = (fall_ok && q.cnt[IDX_FALL_PHASE] == '0) ||
                 (en && tick && q.ph_f == (CNT_W + 1)'(1));

    // Mode steering of the internal drive
    assign modv = q.pwm && (q.dir == '0);
    assign raw = (mode == MODE_FWD) ? {modv, 1'b0, 1'b0, 1'b1} :
                 (mode == MODE_REV) ? {1'b0, 1'b1, modv, 1'b0} :
                 {q.comp, q.prim, q.comp, q.prim};

    // ==========================================================
    // Per-output selection; pairs A/C and B/D share an override
    for (genvar i = 0; i < 4; i++)
    begin : g_out
        logic [1:0] code;
        logic live;
        logic ovr_v;
        assign code = (i % 2 == 1) ? q.ovr[3:2] : q.ovr[1:0];
        assign live = (en ? raw[i] : INACTIVE_LEVELS[i]) ^ q.pol[i];
        assign ovr_v = (code == OVR_HIGH) || ((code == OVR_INACTIVE) &&
                       (INACTIVE_LEVELS[i] ^ q.pol[i]));
        assign sel_v[i] = !q.steer[i] ? (q.sdata[i] ^ q.pol[i]) :
                          shutdown_active_i ? ovr_v : live;
        assign sel_e[i] = !(q.steer[i] && shutdown_active_i &&
                          code == OVR_HIZ);
    end

    // ==========================================================
    // Register read decode; bit 32 marks a mapped address
    function automatic logic [32:0] read_word(
        input logic [AXI_AW-1:0] a, input state_t s);
        logic [32:0] r;
        r = {1'b1, 32'h0000_0000};
        if (a == REG_TIMING_CONTROL)
            r[CTL_W-1:0] = s.timing_control_reg;
        else if (a == REG_POLARITY)
            r[3:0] = s.pol;
        else if (a == REG_STEER)
            r[7:0] = {s.sdata, s.steer};
        else if (a == REG_OVERRIDE)
            r[3:0] = s.ovr;
        else if (a == REG_STATUS)
        begin
            r[3:0] = s.out;
            r[STAT_PRIM] = s.prim;
            r[STAT_COMP] = s.comp;
            r[STAT_PWM] = s.pwm;
            r[STAT_DB_RUN] = (s.db_r != '0) || (s.db_f != '0);
            r[STAT_PH_RUN] = (s.ph_r != '0) || (s.ph_f != '0);
            r[STAT_BL_RUN] = (s.bl_r != '0) || (s.bl_f != '0);
        end
        else
        begin
            r[32] = 1'b0;
            for (int k = 0; k < NUM_CNT; k++)
                if (a == REG_COUNT_BASE + 6'(4 * k))
                begin
                    r[32] = 1'b1;
                    r[CNT_W-1:0] = s.cnt[k];
                end
        end
        return r;
    endfunction

    assign rd = read_word(s_axi_araddr, q);
    assign wr_chk = read_word(q.aw_addr, q);

    // ==========================================================
    // Next state
    always_comb
    begin
        n = q;
        n.rise_sync = {q.rise_sync[1:0], rise_src_i};
        n.fall_sync = {q.fall_sync[1:0], fall_src_i};
        n.rise_lvl = rise_agree ? q.rise_sync[1] : q.rise_lvl;
        n.fall_lvl = fall_agree ? q.fall_sync[1] : q.fall_lvl;
        n.gdiv = tick ? '0 : q.gdiv + 1'b1;
        n.cdiv = cstep ? '0 : q.cdiv + 1'b1;
        n.mode_prev = mode;
        n.out = sel_v;
        n.oe = sel_e;

        // Counters run on generator ticks only, so a later stage
        // starts aligned to the clock the earlier one ended on
        if (tick && q.ph_r != '0)
            n.ph_r = q.ph_r - 1'b1;
        if (tick && q.ph_f != '0)
            n.ph_f = q.ph_f - 1'b1;
        if (tick && q.bl_r != '0)
            n.bl_r = q.bl_r - 1'b1;
        if (tick && q.bl_f != '0)
            n.bl_f = q.bl_f - 1'b1;
        // First tick only aligns to the generator clock, so N full
        // periods follow it and the delay lands in N..N+1 periods
        if (rise_ok && q.cnt[IDX_RISE_PHASE] != '0)
            n.ph_r = {1'b0, q.cnt[IDX_RISE_PHASE]} + 1'b1;
        if (fall_ok && q.cnt[IDX_FALL_PHASE] != '0)
            n.ph_f = {1'b0, q.cnt[IDX_FALL_PHASE]} + 1'b1;

        // Dead-band timers, chain or counter per source bit
        if ((q.timing_control_reg[CTL_RISE_DB_SRC] ? tick : cstep) &&
            q.db_r != '0)
        begin
            n.db_r = q.db_r - 1'b1;
            if (q.db_r == CNT_W'(1))
                n.prim = 1'b1;
        end
        if ((q.timing_control_reg[CTL_FALL_DB_SRC] ? tick : cstep) &&
            q.db_f != '0)
        begin
            n.db_f = q.db_f - 1'b1;
            if (q.db_f == CNT_W'(1))
                n.comp = 1'b1;
        end
        if ((q.dir_sync ? tick : cstep) && q.dir != '0)
            n.dir = q.dir - 1'b1;

        // Direction change in full bridge reloads the hold-off
        if (q.mode_prev == MODE_FWD && mode == MODE_REV)
        begin
            n.dir = q.cnt[IDX_FALL_DEADBAND];
            n.dir_sync = q.timing_control_reg[CTL_FALL_DB_SRC];
        end
        if (q.mode_prev == MODE_REV && mode == MODE_FWD)
        begin
            n.dir = q.cnt[IDX_RISE_DEADBAND];
            n.dir_sync = q.timing_control_reg[CTL_RISE_DB_SRC];
        end

        // Rising event; a falling event in the same cycle wins
        if (rev)
        begin
            n.comp = 1'b0;
            n.pwm = 1'b1;
            n.db_f = '0;
            n.bl_r = q.cnt[IDX_RISE_BLANK];
            if (half && q.cnt[IDX_RISE_DEADBAND] != '0)
                n.db_r = q.cnt[IDX_RISE_DEADBAND];
            else
                n.prim = 1'b1;
        end
        if (fev)
        begin
            n.prim = 1'b0;
            n.pwm = 1'b0;
            n.db_r = '0;
            n.bl_f = q.cnt[IDX_FALL_BLANK];
            if (half && q.cnt[IDX_FALL_DEADBAND] != '0)
                n.db_f = q.cnt[IDX_FALL_DEADBAND];
            else
                n.comp = 1'b1;
        end

        // Disabled core rests in the inactive drive state
        if (!en)
        begin
            n.prim = 1'b0;
            n.comp = 1'b1;
            n.pwm = 1'b0;
            n.ph_r = '0;
            n.ph_f = '0;
            n.bl_r = '0;
            n.bl_f = '0;
            n.db_r = '0;
            n.db_f = '0;
            n.dir = '0;
        end

        // AXI write: address and data accepted in either order
        if (s_axi_awvalid && s_axi_awready)
        begin
            n.aw_got = 1'b1;
            n.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            n.w_got = 1'b1;
            n.w_data = s_axi_wdata;
            n.w_strb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready)
            n.bvalid = 1'b0;
        if (q.aw_got && q.w_got && !q.bvalid)
        begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = wr_chk[32] ? RESP_OKAY : RESP_SLVERR;
            // Every field lives in byte lane 0
            if (q.w_strb[0])
            begin
                if (q.aw_addr == REG_TIMING_CONTROL)
                    n.timing_control_reg = q.w_data[CTL_W-1:0];
                if (q.aw_addr == REG_POLARITY)
                    n.pol = q.w_data[3:0];
                if (q.aw_addr == REG_STEER)
                begin
                    n.steer = q.w_data[3:0];
                    n.sdata = q.w_data[STEER_DATA_LSB +: 4];
                end
                if (q.aw_addr == REG_OVERRIDE)
                    n.ovr = q.w_data[3:0];
                for (int k = 0; k < NUM_CNT; k++)
                    if (q.aw_addr == REG_COUNT_BASE + 6'(4 * k))
                        n.cnt[k] = q.w_data[CNT_W-1:0];
            end
        end

        // AXI read: one cycle from address to data
        if (q.rvalid && s_axi_rready)
            n.rvalid = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            n.rvalid = 1'b1;
            n.rdata = rd[31:0];
            n.rresp = rd[32] ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // ==========================================================
    // State register; all-zero reset releases the pins
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            q <= '0;
        else
            q <= n;
    end

    // ==========================================================
    // Ports
    assign s_axi_awready = !q.aw_got && !q.bvalid;
    assign s_axi_wready = !q.w_got && !q.bvalid;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign {out_d_o, out_c_o, out_b_o, out_a_o} = q.out;
    assign {out_d_oe_o, out_c_oe_o, out_b_oe_o, out_a_oe_o} = q.oe;

    // ==========================================================
    // Assertions
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    fall_clears_prim_a: assert property (fev |=> !q.prim)
        else $error("primary still on after falling event");
    comp_immediate_a: assert property (fev && en && (half ?
        q.cnt[IDX_FALL_DEADBAND] == '0 : 1'b1) |=> q.comp)
        else $error("complement late with zero dead band");
    disabled_state_a: assert property (!en [*2] |-> !q.prim && q.comp)
        else $error("disabled drive state wrong");
    static_steer_a: assert property (!q.steer[0] |=>
        out_a_o == $past(q.sdata[0] ^ q.pol[0]))
        else $error("static steering data not driven");
    hiz_override_a: assert property (q.steer[1] && shutdown_active_i &&
        q.ovr[3:2] == OVR_HIZ |=> !out_b_oe_o)
        else $error("tri-state override not released");
    rise_db_hold_a: assert property (rev && !fev && en && half &&
        q.cnt[IDX_RISE_DEADBAND] != '0 |=> !q.prim [*2])
        else $error("primary on inside rising dead band");
    fall_db_hold_a: assert property (fev && en && half &&
        q.cnt[IDX_FALL_DEADBAND] != '0 |=> !q.comp)
        else $error("complement on inside falling dead band");
    no_overlap_a: assert property (!(q.prim && q.comp))
        else $error("primary and complement both on");
    rise_blank_a: assert property (rise_in && q.bl_f != '0 |=>
        $stable(q.ph_r) || q.ph_r < $past(q.ph_r))
        else $error("blanked rising input restarted phase");
    phase_pass_a: assert property (rise_ok &&
        q.cnt[IDX_RISE_PHASE] == '0 |-> rev)
        else $error("zero phase count did not pass event");
    fwd_drive_a: assert property (en && mode == MODE_FWD && q.steer[0] &&
        !shutdown_active_i |=> out_a_o == !$past(q.pol[0]))
        else $error("forward bridge output A not held on");
endmodule

//--- pkg/cog_timing_pkg.sv
// Shared constants for the complementary output timing core
package cog_timing_pkg;
    // ==========================================================
    // Clocking and generator clock
    localparam int SYS_CLK_HZ = 200_000_000;
    localparam int GEN_INT_OSC_HZ = 8_000_000;
    localparam int GEN_INT_DIV = SYS_CLK_HZ / GEN_INT_OSC_HZ;
    localparam int GEN_INSTR_DIV = 4;
    localparam int DLY_ELEM_NS = 5;
    localparam int DLY_ELEM_CYC =
        (DLY_ELEM_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;

    // ==========================================================
    // Widths
    localparam int CNT_W = 6;
    localparam int NUM_CNT = 6;
    localparam int AXI_AW = 6;
    localparam int CTL_W = 7;

    // ==========================================================
    // Register byte offsets
    localparam logic [5:0] REG_TIMING_CONTROL = 6'h00;
    localparam logic [5:0] REG_POLARITY = 6'h04;
    localparam logic [5:0] REG_STEER = 6'h08;
    localparam logic [5:0] REG_OVERRIDE = 6'h0c;
    localparam logic [5:0] REG_COUNT_BASE = 6'h10;
    localparam logic [5:0] REG_STATUS = 6'h28;

    // ==========================================================
    // Count register indices, one word each above the base
    localparam int IDX_RISE_DEADBAND = 0;
    localparam int IDX_FALL_DEADBAND = 1;
    localparam int IDX_RISE_BLANK = 2;
    localparam int IDX_FALL_BLANK = 3;
    localparam int IDX_RISE_PHASE = 4;
    localparam int IDX_FALL_PHASE = 5;

    // ==========================================================
    // Field positions
    localparam int CTL_ENABLE = 0;
    localparam int CTL_MODE_LSB = 1;
    localparam int CTL_CLKSEL_LSB = 3;
    localparam int CTL_RISE_DB_SRC = 5;
    localparam int CTL_FALL_DB_SRC = 6;
    localparam int STEER_DATA_LSB = 4;
    localparam int STAT_PRIM = 4;
    localparam int STAT_COMP = 5;
    localparam int STAT_PWM = 6;
    localparam int STAT_DB_RUN = 7;
    localparam int STAT_PH_RUN = 8;
    localparam int STAT_BL_RUN = 9;

    // ==========================================================
    // Encodings
    localparam logic [1:0] MODE_HALF = 2'h0;
    localparam logic [1:0] MODE_FWD = 2'h1;
    localparam logic [1:0] MODE_REV = 2'h2;
    localparam logic [1:0] CS_INT_OSC = 2'h0;
    localparam logic [1:0] CS_INSTR = 2'h1;
    localparam logic [1:0] OVR_HIGH = 2'h1;
    localparam logic [1:0] OVR_HIZ = 2'h2;
    localparam logic [1:0] OVR_INACTIVE = 2'h3;
    localparam logic [3:0] INACTIVE_LEVELS = 4'ha;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- sim/switch_driver_model.sv
// Power switch driver model on leg A/B of the half bridge
`timescale 1ns/1ps
module switch_driver_model (
    // Clock
    input wire logic clk_sys_i,
    // Gate drive pins and enables, live while PWM runs
    input wire logic [3:0] pins_i,
    input wire logic [3:0] oe_i,
    input wire logic live_i,
    // Shoot-through cycle count
    output logic [7:0] overlap_cnt_o
);
    // =========================================================
    // Both switches on at once would short the supply
    initial overlap_cnt_o = 8'h00;
    always @(posedge clk_sys_i)
    begin
        if (live_i && (&pins_i[1:0]) && (&oe_i[1:0]))
        begin
            overlap_cnt_o <= overlap_cnt_o + 8'h01;
        end
    end
endmodule

//--- sim/complementary_output_timing_tb_top.sv
// Self-checking bench for the complementary output timing core
`timescale 1ns/1ps
module complementary_output_timing_tb_top;
    import cog_timing_pkg::*;
    logic clk_sys_i, reset_n_i = 1'b0, live = 1'b0;
    logic rise_src_i = 1'b0, fall_src_i = 1'b0, shutdown_active_i = 1'b0;
    logic [5:0] awaddr = 6'h00, araddr = 6'h00;
    logic [31:0] wdata = 32'h0, d;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] rdata;
    logic [1:0] bresp, rresp, r;
    wire [3:0] pins, oe;
    wire [7:0] overlap;
    logic [3:0] pins_q;
    int error_cnt = 0, tests_run = 0, la, lf;
    int dv[3] = '{1, GEN_INSTR_DIV, GEN_INT_DIV};
    time ev_t, ta_r, ta_f, tb_r, tb_f, t;
    typedef struct packed {
        logic [7:0] ctl, pol, steer, ovr;
        logic sd;
        logic [3:0] pins, oe;
    } row_t;
    // Static data, polarity, inactive state and the four overrides
    row_t rows [10] = '{
        '{8'h10, 8'h00, 8'h50, 8'h00, 1'b0, 4'h5, 4'hf},
        '{8'h10, 8'h0f, 8'h50, 8'h00, 1'b0, 4'ha, 4'hf},
        '{8'h10, 8'h00, 8'h0f, 8'h00, 1'b0, 4'ha, 4'hf},
        '{8'h10, 8'h0f, 8'h0f, 8'h00, 1'b0, 4'h5, 4'hf},
        '{8'h11, 8'h00, 8'h0f, 8'h00, 1'b0, 4'ha, 4'hf},
        '{8'h11, 8'h0f, 8'h0f, 8'h00, 1'b1, 4'h0, 4'hf},
        '{8'h11, 8'h0f, 8'h0f, 8'h05, 1'b1, 4'hf, 4'hf},
        '{8'h11, 8'h0f, 8'h0f, 8'h0a, 1'b1, 4'h0, 4'h0},
        '{8'h11, 8'h0f, 8'h0f, 8'h0f, 1'b1, 4'h5, 4'hf},
        '{8'h10, 8'h00, 8'hc3, 8'h00, 1'b0, 4'he, 4'hf}};

    complementary_output_timing i_dut (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .rise_src_i(rise_src_i), .fall_src_i(fall_src_i),
        .shutdown_active_i(shutdown_active_i),
        .out_a_o(pins[0]), .out_b_o(pins[1]), .out_c_o(pins[2]),
        .out_d_o(pins[3]), .out_a_oe_o(oe[0]), .out_b_oe_o(oe[1]),
        .out_c_oe_o(oe[2]), .out_d_oe_o(oe[3]),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    switch_driver_model i_sw (.clk_sys_i(clk_sys_i), .pins_i(pins),
        .oe_i(oe), .live_i(live), .overlap_cnt_o(overlap));

    // =========================================================
    // Clock, watchdog and edge stamps of legs A and B
    initial
    begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        error_cnt++;
        end_sim();
    end
    always @(posedge clk_sys_i)
    begin
        pins_q <= pins;
        if (pins[0] & ~pins_q[0]) ta_r <= $time;
        if (~pins[0] & pins_q[0]) ta_f <= $time;
        if (pins[1] & ~pins_q[1]) tb_r <= $time;
        if (~pins[1] & pins_q[1]) tb_f <= $time;
    end

    // =========================================================
    // Compare, bus and stimulus tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time,
                got, exp);
        end
    endtask
    task automatic inr(input int g, input int lo, input int hi);
        tests_run++;
        if (g < lo || g > hi)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h..%h", $time, g,
                lo, hi);
        end
    endtask
    function automatic int gap(input time a, input time b);
        return (int'(a) - int'(b)) / 5;
    endfunction
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    // Address and data offered together; bready raised with them and left high
    task automatic wr(input logic [5:0] a, input logic [31:0] v);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        @(posedge clk_sys_i iff (awready && wready));
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        // bready stays up after the answer; a following write drives it high again
        @(posedge clk_sys_i iff bvalid);
        check({30'h0, bresp}, {30'h0, RESP_OKAY});
    endtask
    task automatic rd(input logic [5:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        @(posedge clk_sys_i iff arready);
        arvalid <= 1'b0;
        @(posedge clk_sys_i iff rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    // Counts packed as phase, blanking, dead band; falling above rising
    task automatic cfg(input logic [7:0] c, input logic [35:0] n);
        wr(REG_TIMING_CONTROL, {24'h0, c});
        for (int k = 0; k < 6; k++)
            wr(REG_COUNT_BASE + 6'(4 * k), {26'h0, n[6 * k +: 6]});
    endtask
    // Sources held six cycles so the synchroniser settles
    task automatic fire(input logic rise);
        if (rise) rise_src_i <= 1'b1;
        else fall_src_i <= 1'b1;
        ev_t = $time;
        idle(6);
        rise_src_i <= 1'b0;
        fall_src_i <= 1'b0;
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // =========================================================
    // Main sequence
    initial
    begin
        idle(20);
        check({28'h0, oe}, 32'h0);
        reset_n_i <= 1'b1;
        idle(3);
        check({24'h0, oe, pins}, 32'hf0);
        foreach (rows[i])
        begin
            wr(REG_TIMING_CONTROL, {24'h0, rows[i].ctl});
            wr(REG_POLARITY, {24'h0, rows[i].pol});
            wr(REG_STEER, {24'h0, rows[i].steer});
            wr(REG_OVERRIDE, {24'h0, rows[i].ovr});
            shutdown_active_i <= rows[i].sd;
            idle(4);
            check({28'h0, oe}, {28'h0, rows[i].oe});
            check({28'h0, pins & rows[i].oe},
                {28'h0, rows[i].pins});
        end
        rd(6'h2c);
        check({r, d[29:0]}, {RESP_SLVERR, 30'h0});
        // Zero counts: baseline latencies, complement at primary turn-off
        wr(REG_STEER, 32'h0f);
        live <= 1'b1;
        cfg(8'h11, 36'h0);
        fire(1'b1);
        idle(30);
        fire(1'b0);
        idle(30);
        la = gap(ta_f, ev_t);
        lf = gap(tb_r, ev_t);
        check(32'(tb_r == ta_f), 32'h1);
        // Delay chain, then synchronous counter
        for (int m = 0; m < 2; m++)
        begin
            cfg(m ? 8'h71 : 8'h11, {24'h0, 6'd9, 6'd6});
            fire(1'b1);
            idle(60);
            inr(gap(ta_r, tb_f), 6,
                7);
            fire(1'b0);
            idle(60);
            inr(gap(tb_r, ta_f), 9, 10);
        end
        // Falling event inside the rising dead band
        cfg(8'h71, {24'h0, 6'd8, 6'd30});
        t = ta_r;
        fire(1'b1);
        idle(4);
        fire(1'b0);
        idle(80);
        check({30'h0, pins[1:0]}, 32'h2);
        check(32'(ta_r == t), 32'h1);
        inr(gap(tb_r, ev_t), 8, lf + 9);
        // Falls masked while rise blanking runs, passed after it
        cfg(8'h11, {18'h0, 6'd40, 12'h0});
        fire(1'b1);
        idle(4);
        fire(1'b0);
        idle(10);
        check({31'h0, pins[0]}, 32'h1);
        idle(60);
        fire(1'b0);
        idle(10);
        check({31'h0, pins[0]}, 32'h0);
        // Falling phase delay at each generator clock
        for (int k = 0; k < 3; k++)
        begin
            cfg(8'h01 | (8'(2 - k) << 3), {6'd3, 30'h0});
            fire(1'b1);
            idle(30);
            fire(1'b0);
            idle(250);
            inr(gap(ta_f, ev_t) - la, 3 * dv[k],
                4 * dv[k] + 1);
        end
        // Forward full bridge holds output A on at 100%
        wr(REG_TIMING_CONTROL, 32'h13);
        idle(4);
        check({31'h0, pins[0]}, 32'h1);
        check({24'h0, overlap}, 32'h0);
        end_sim();
    end
endmodule
